// ===== design/an_np_pkg.sv
// constants, field layouts and carrier types for the next page register bank
// assumes a single core clock and a serial management frame decoder in front
// How it works
// - page-received and parallel-fault flags latch high
// - partner next-page and autoneg ability reported read-only
// - own next-page ability reads one, upper zero
// - more-pages, message, ack2 writable; bit14 zero
// - toggle bits read-only, kept by device
// - writable eleven-bit code field, reset one
// - received partner page exposed read-only
package an_np_pkg;

  // register offsets
  localparam logic [4:0]  REG_EXPANSION  = 5'h06;
  localparam logic [4:0]  REG_NP_TX      = 5'h07;
  localparam logic [4:0]  REG_NP_RX      = 5'h08;

  // expansion register bit positions
  localparam int          BIT_PAR_FAULT  = 4;
  localparam int          BIT_LP_NP_ABLE = 3;
  localparam int          BIT_NP_ABLE    = 2;
  localparam int          BIT_PAGE_RX    = 1;
  localparam int          BIT_LP_AN_ABLE = 0;

  // next page register bit positions
  localparam int          BIT_MORE       = 15;
  localparam int          BIT_RSVD       = 14;
  localparam int          BIT_MSG        = 13;
  localparam int          BIT_ACK2       = 12;
  localparam int          BIT_TOGGLE     = 11;
  localparam int          CODE_W         = 11;

  // reset values
  localparam logic        NP_ABLE_VALUE  = 1'b1;
  localparam logic        TX_MORE_RST    = 1'b0;
  localparam logic        TX_MSG_RST     = 1'b1;
  localparam logic        TX_ACK2_RST    = 1'b0;
  localparam logic [10:0] TX_CODE_RST    = 11'h001;

  // management frame layout
  localparam logic [5:0]  PREAMBLE_BITS  = 6'h20;
  localparam logic [4:0]  HDR_BITS       = 5'h0e;
  localparam logic [4:0]  TA_BITS        = 5'h02;
  localparam logic [4:0]  DATA_BITS      = 5'h10;
  localparam logic [1:0]  FRAME_START    = 2'b01;
  localparam logic [1:0]  OP_READ        = 2'b10;
  localparam logic [1:0]  OP_WRITE       = 2'b01;

  typedef struct packed {
    logic              more_pages;
    logic              msg_page;
    logic              ack2;
    logic              toggle;
    logic [CODE_W-1:0] code;
  } np_page_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } mgmt_req_t;

  // register image of a page; reserved bit 14 always zero
  function automatic logic [15:0] page_word(input np_page_t p);
    page_word = {p.more_pages, 1'b0, p.msg_page, p.ack2, p.toggle, p.code};
  endfunction : page_word

endpackage : an_np_pkg

// ===== design/mdio_frame.sv
// serial management frame decoder: preamble, header, turnaround, data
// assumes mdc and mdio_in already synchronous to core_clk and slow against it
`timescale 1ns/1ps
`default_nettype none
module mdio_frame
  import an_np_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic [4:0]        phy_addr,
  input  wire logic              mdc,
  input  wire logic              mdio_in,
  output var  logic              mdio_out,
  output var  logic              mdio_oe,
  output var  an_np_pkg::mgmt_req_t req,
  input  wire logic [15:0]       rd_data
);
  import an_np_pkg::*;

  typedef enum logic [1:0] {st_idle, st_hdr, st_ta, st_data} frame_state_t;

  frame_state_t state, next_state;
  logic         mdc_prev;
  logic         rise;
  logic [5:0]   ones_cnt, next_ones_cnt;
  logic [4:0]   bit_cnt, next_bit_cnt;
  logic [13:0]  hdr, next_hdr;
  logic [15:0]  data_sr, next_data_sr;
  logic         is_read, next_is_read;
  logic         hit, next_hit;
  logic         next_mdio_out, next_mdio_oe;
  mgmt_req_t    next_req;
  logic [13:0]  hdr_full;

  assign rise     = mdc & ~mdc_prev;
  assign hdr_full = {hdr[12:0], mdio_in};

  ////////////////////////////////////////////////////////////////////////
  // frame sequencing on each rising management clock edge
  always_comb begin
    next_state    = state;
    next_ones_cnt = ones_cnt;
    next_bit_cnt  = bit_cnt;
    next_hdr      = hdr;
    next_data_sr  = data_sr;
    next_is_read  = is_read;
    next_hit      = hit;
    next_mdio_out = mdio_out;
    next_mdio_oe  = mdio_oe;
    next_req      = '0;
    // read data is captured the cycle after the request
    if (req.rd) begin
      next_data_sr = rd_data;
    end
    if (rise) begin
      case (state)
        st_idle: begin
          if (mdio_in) begin
            if (ones_cnt != PREAMBLE_BITS) next_ones_cnt = ones_cnt + 6'h01;
          end else begin
            if (ones_cnt == PREAMBLE_BITS) begin
              next_state   = st_hdr;
              next_hdr     = '0;
              next_bit_cnt = 5'h01;
            end
            next_ones_cnt = '0;
          end
        end
        st_hdr: begin
          next_hdr     = hdr_full;
          next_bit_cnt = bit_cnt + 5'h01;
          if (bit_cnt == HDR_BITS - 5'h01) begin
            next_bit_cnt = '0;
            next_hit     = (hdr_full[9:5] == phy_addr);
            next_is_read = (hdr_full[11:10] == OP_READ);
            // bad start or opcode drops back to preamble hunt
            if (hdr_full[13:12] != FRAME_START ||
                (hdr_full[11:10] != OP_READ && hdr_full[11:10] != OP_WRITE)) begin
              next_state = st_idle;
            end else begin
              next_state = st_ta;
              if (hdr_full[9:5] == phy_addr && hdr_full[11:10] == OP_READ) begin
                next_req.rd   = 1'b1;
                next_req.addr = hdr_full[4:0];
              end
            end
          end
        end
        st_ta: begin
          next_bit_cnt = bit_cnt + 5'h01;
          if (is_read && hit) begin
            next_mdio_oe = 1'b1;
            if (bit_cnt == 5'h00) begin
              next_mdio_out = 1'b0;
            end else begin
              next_mdio_out = data_sr[15];
              next_data_sr  = {data_sr[14:0], 1'b0};
            end
          end
          if (bit_cnt == TA_BITS - 5'h01) begin
            next_state   = st_data;
            next_bit_cnt = '0;
          end
        end
        st_data: begin
          next_bit_cnt = bit_cnt + 5'h01;
          if (is_read) begin
            next_mdio_out = data_sr[15];
            next_data_sr  = {data_sr[14:0], 1'b0};
          end else begin
            next_data_sr = {data_sr[14:0], mdio_in};
          end
          if (bit_cnt == DATA_BITS - 5'h01) begin
            next_state    = st_idle;
            next_mdio_oe  = 1'b0;
            next_mdio_out = 1'b0;
            next_ones_cnt = '0;
            if (!is_read && hit) begin
              next_req.wr    = 1'b1;
              next_req.addr  = hdr[4:0];
              next_req.wdata = {data_sr[14:0], mdio_in};
            end
          end
        end
        default: begin
          next_state = st_idle;
        end
      endcase
    end
  end

  // registers only
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= st_idle;
      mdc_prev <= 1'b0;
      ones_cnt <= '0;
      bit_cnt  <= '0;
      hdr      <= '0;
      data_sr  <= '0;
      is_read  <= 1'b0;
      hit      <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
      req      <= '0;
    end else begin
      state    <= next_state;
      mdc_prev <= mdc;
      ones_cnt <= next_ones_cnt;
      bit_cnt  <= next_bit_cnt;
      hdr      <= next_hdr;
      data_sr  <= next_data_sr;
      is_read  <= next_is_read;
      hit      <= next_hit;
      mdio_out <= next_mdio_out;
      mdio_oe  <= next_mdio_oe;
      req      <= next_req;
    end
  end

endmodule : mdio_frame
`default_nettype wire

// ===== design/autoneg_next_page_regs.sv
// next page exchange register bank: expansion, transmit page, partner page
// assumes the arbitration logic drives one-cycle event pulses on core_clk
`timescale 1ns/1ps
`default_nettype none
module autoneg_next_page_regs
  import an_np_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic [4:0]           phy_addr,
  input  wire logic                 mdc,
  input  wire logic                 mdio_in,
  output var  logic                 mdio_out,
  output var  logic                 mdio_oe,
  input  wire logic                 page_rx_valid,
  input  wire an_np_pkg::np_page_t  page_rx,
  input  wire logic                 par_fault_event,
  input  wire logic                 partner_np_able,
  input  wire logic                 partner_an_able,
  output var  an_np_pkg::np_page_t  tx_page,
  output var  logic                 tx_page_pending,
  input  wire logic                 tx_page_taken
);
  import an_np_pkg::*;

  mgmt_req_t   req;
  logic [15:0] rd_data;
  logic        flag_page_rx, next_flag_page_rx;
  logic        flag_par_fault, next_flag_par_fault;
  logic        lp_np_able, next_lp_np_able;
  logic        lp_an_able, next_lp_an_able;
  np_page_t    next_tx_page;
  np_page_t    rx_page, next_rx_page;
  logic        next_tx_page_pending;
  logic        clr_expansion;
  logic        wr_tx;
  logic [15:0] expansion_word;

  ////////////////////////////////////////////////////////////////////////
  // management frame front end
  mdio_frame u_frame (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .phy_addr (phy_addr),
    .mdc      (mdc),
    .mdio_in  (mdio_in),
    .mdio_out (mdio_out),
    .mdio_oe  (mdio_oe),
    .req      (req),
    .rd_data  (rd_data)
  );

  assign clr_expansion = req.rd && (req.addr == REG_EXPANSION);
  assign wr_tx         = req.wr && (req.addr == REG_NP_TX);

  always_comb begin
    expansion_word                 = '0;
    expansion_word[BIT_PAR_FAULT]  = flag_par_fault;
    expansion_word[BIT_LP_NP_ABLE] = lp_np_able;
    expansion_word[BIT_NP_ABLE]    = NP_ABLE_VALUE;
    expansion_word[BIT_PAGE_RX]    = flag_page_rx;
    expansion_word[BIT_LP_AN_ABLE] = lp_an_able;
  end

  // read mux; offsets outside this bank answer zero
  always_comb begin
    case (req.addr)
      REG_EXPANSION: rd_data = expansion_word;
      REG_NP_TX:     rd_data = page_word(tx_page);
      REG_NP_RX:     rd_data = page_word(rx_page);
      default:       rd_data = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // status and page state
  always_comb begin
    // latch high, read clears, set wins
    next_flag_page_rx   = page_rx_valid | (flag_page_rx & ~clr_expansion);
    next_flag_par_fault = par_fault_event | (flag_par_fault & ~clr_expansion);
    next_lp_np_able     = partner_np_able;
    next_lp_an_able     = partner_an_able;
    next_rx_page        = page_rx_valid ? page_rx : rx_page;
    next_tx_page        = tx_page;
    if (wr_tx) begin
      next_tx_page.more_pages = req.wdata[BIT_MORE];
      next_tx_page.msg_page   = req.wdata[BIT_MSG];
      next_tx_page.ack2       = req.wdata[BIT_ACK2];
      next_tx_page.code       = req.wdata[CODE_W-1:0];
    end
    // toggle kept by device, flips per sent word
    if (tx_page_taken) begin
      next_tx_page.toggle = ~tx_page.toggle;
    end
    // new page pending until taken, write wins
    next_tx_page_pending = wr_tx | (tx_page_pending & ~tx_page_taken);
  end

  // registers only
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_page_rx       <= 1'b0;
      flag_par_fault     <= 1'b0;
      lp_np_able         <= 1'b0;
      lp_an_able         <= 1'b0;
      rx_page            <= '0;
      tx_page.more_pages <= TX_MORE_RST;
      tx_page.msg_page   <= TX_MSG_RST;
      tx_page.ack2       <= TX_ACK2_RST;
      tx_page.toggle     <= 1'b0;
      tx_page.code       <= TX_CODE_RST;
      tx_page_pending    <= 1'b0;
    end else begin
      flag_page_rx    <= next_flag_page_rx;
      flag_par_fault  <= next_flag_par_fault;
      lp_np_able      <= next_lp_np_able;
      lp_an_able      <= next_lp_an_able;
      rx_page         <= next_rx_page;
      tx_page         <= next_tx_page;
      tx_page_pending <= next_tx_page_pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_page_rx_latch;
    @(posedge core_clk) disable iff (sys_rst)
    page_rx_valid |=> flag_page_rx [*1] ##0 (rx_page == $past(page_rx));
  endproperty
  a_page_rx_latch: assert property (p_page_rx_latch) else $error("page flag or page lost");

  property p_fault_held;
    @(posedge core_clk) disable iff (sys_rst)
    (flag_par_fault && !clr_expansion) |=> flag_par_fault;
  endproperty
  a_fault_held: assert property (p_fault_held) else $error("fault flag dropped unread");

  property p_read_clears;
    @(posedge core_clk) disable iff (sys_rst)
    (clr_expansion && !page_rx_valid && !par_fault_event)
      |=> !flag_page_rx && !flag_par_fault;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flags not cleared by read");

  property p_partner_ability;
    @(posedge core_clk) disable iff (sys_rst)
    ##1 (expansion_word[BIT_LP_NP_ABLE] == $past(partner_np_able)) &&
        (expansion_word[BIT_LP_AN_ABLE] == $past(partner_an_able));
  endproperty
  a_partner_ability: assert property (p_partner_ability) else $error("ability bits wrong");

  property p_expansion_fixed;
    @(posedge core_clk) disable iff (sys_rst)
    clr_expansion |-> (rd_data[15:5] == 11'h000) && rd_data[BIT_NP_ABLE];
  endproperty
  a_expansion_fixed: assert property (p_expansion_fixed) else $error("fixed bits wrong");

  property p_tx_write;
    @(posedge core_clk) disable iff (sys_rst)
    wr_tx |=> (page_word(tx_page) & 16'hb7ff) == ($past(req.wdata) & 16'hb7ff);
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("transmit page write lost");

  property p_toggle_ro;
    @(posedge core_clk) disable iff (sys_rst)
    (wr_tx && !tx_page_taken) |=> $stable(tx_page.toggle) &&
      ((page_word(tx_page) & 16'h4000) == 16'h0000);
  endproperty
  a_toggle_ro: assert property (p_toggle_ro) else $error("toggle changed by write");

  property p_code_write;
    @(posedge core_clk) disable iff (sys_rst)
    wr_tx |=> tx_page.code == $past(req.wdata[CODE_W-1:0]);
  endproperty
  a_code_write: assert property (p_code_write) else $error("code field write lost");

  property p_rx_hold;
    @(posedge core_clk) disable iff (sys_rst)
    !page_rx_valid |=> $stable(rx_page);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("partner page changed unprompted");

  property p_pending;
    @(posedge core_clk) disable iff (sys_rst)
    wr_tx |=> tx_page_pending;
  endproperty
  a_pending: assert property (p_pending) else $error("written page not pending");

  property p_fault_set;
    @(posedge core_clk) disable iff (sys_rst)
    par_fault_event |=> flag_par_fault;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not latched");

  property p_toggle_flip;
    @(posedge core_clk) disable iff (sys_rst)
    tx_page_taken |=> (tx_page.toggle != $past(tx_page.toggle));
  endproperty
  a_toggle_flip: assert property (p_toggle_flip) else $error("toggle not flipped");

  property p_pending_clear;
    @(posedge core_clk) disable iff (sys_rst)
    (tx_page_taken && !wr_tx) |=> !tx_page_pending;
  endproperty
  a_pending_clear: assert property (p_pending_clear) else $error("pending not cleared");

  // reserved bit and toggle as the station reads the transmit page back
  property p_tx_read_image;
    @(posedge core_clk) disable iff (sys_rst)
    (req.rd && (req.addr == REG_NP_TX)) |->
      (rd_data[BIT_RSVD] == 1'b0) && (rd_data[BIT_TOGGLE] == tx_page.toggle);
  endproperty
  a_tx_read_image: assert property (p_tx_read_image) else $error("tx image wrong");

  // reserved bit and toggle as the station reads the partner page back
  property p_rx_read_image;
    @(posedge core_clk) disable iff (sys_rst)
    (req.rd && (req.addr == REG_NP_RX)) |->
      (rd_data[BIT_RSVD] == 1'b0) && (rd_data[BIT_TOGGLE] == rx_page.toggle);
  endproperty
  a_rx_read_image: assert property (p_rx_read_image) else $error("rx image wrong");

endmodule : autoneg_next_page_regs
`default_nettype wire

// ===== dv/mdio_station.sv
// station management controller model: drives mdc and the shared data line
// assumes core_clk free running; line has a pull-up when nobody drives it
`timescale 1ns/1ps
`default_nettype none
module mdio_station
  import an_np_pkg::*;
(
  input  wire logic core_clk,
  output var  logic mdc,
  output wire logic mdio_in,
  input  wire logic mdio_out,
  input  wire logic mdio_oe
);
  import an_np_pkg::*;

  logic drv_en;
  logic drv_val;
  int   half_cycles;

  // wired level: model, device, else pull-up so a released line reads one
  assign mdio_in = drv_en ? drv_val : (mdio_oe ? mdio_out : 1'b1);

  initial begin
    mdc         = 1'b0;
    drv_en      = 1'b0;
    drv_val     = 1'b1;
    half_cycles = 2;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one mdc period; changes land just after a core edge, sample at the rise
  task automatic clk_bit(input logic b, input logic en, output logic smp);
    drv_en  = en;
    drv_val = b;
    repeat (half_cycles) @(posedge core_clk);
    #1 mdc = 1'b1;
    smp = mdio_in;
    repeat (half_cycles) @(posedge core_clk);
    #1 mdc = 1'b0;
  endtask : clk_bit

  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] reg_a,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic        s;
    logic [13:0] hdr;
    hdr = {2'b01, op, phy, reg_a};
    rd  = 16'h0000;
    for (int i = 0; i < 32; i++) clk_bit(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) clk_bit(hdr[i], 1'b1, s);
    if (op == OP_WRITE) begin
      clk_bit(1'b1, 1'b1, s);
      clk_bit(1'b0, 1'b1, s);
      for (int i = 15; i >= 0; i--) clk_bit(wd[i], 1'b1, s);
    end else begin
      // turnaround: line released to the device
      clk_bit(1'b1, 1'b0, s);
      clk_bit(1'b1, 1'b0, s);
      for (int i = 15; i >= 0; i--) begin
        clk_bit(1'b1, 1'b0, s);
        rd[i] = s;
      end
    end
    drv_en = 1'b0;
    // let an edge pass so a following frame never retoggles the line at once
    @(posedge core_clk);
    #1;
  endtask : frame
endmodule : mdio_station
`default_nettype wire

// ===== dv/tb_autoneg_next_page_regs.sv
// self-checking bench for the next page register bank
// assumes the station model drives the management pins; arbitration by tasks
`timescale 1ns/1ps
`default_nettype none
module tb_autoneg_next_page_regs;
  import an_np_pkg::*;

  logic     core_clk;
  logic     sys_rst;
  logic     mdc;
  wire      mdio_in;
  logic     mdio_out;
  logic     mdio_oe;
  logic     page_rx_valid;
  np_page_t page_rx;
  logic     par_fault_event;
  logic     partner_np_able;
  logic     partner_an_able;
  np_page_t tx_page;
  logic     tx_page_pending;
  logic     tx_page_taken;
  int       err_count;
  int       checked;
  logic [15:0] rd;

  localparam logic [4:0] MY_PHY = 5'h03;

  autoneg_next_page_regs u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .phy_addr(MY_PHY),
    .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .page_rx_valid(page_rx_valid), .page_rx(page_rx), .par_fault_event(par_fault_event),
    .partner_np_able(partner_np_able), .partner_an_able(partner_an_able),
    .tx_page(tx_page), .tx_page_pending(tx_page_pending), .tx_page_taken(tx_page_taken));

  mdio_station u_sta (.core_clk(core_clk), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe));

  // 20 MHz core clock
  always #25 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic rd_reg(input logic [4:0] a, input logic [4:0] phy);
    u_sta.frame(OP_READ, phy, a, 16'h0000, rd);
  endtask : rd_reg

  // writes land two core cycles after the last rise; leave margin
  task automatic wr_reg(input logic [4:0] a, input logic [4:0] phy, input logic [15:0] d);
    u_sta.frame(OP_WRITE, phy, a, d, rd);
    repeat (4) @(posedge core_clk);
    #1;
  endtask : wr_reg

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_reg(REG_EXPANSION, MY_PHY);
    chk("reg6 reset", 16'h0004, rd);
    rd_reg(REG_NP_TX, MY_PHY);
    chk("reg7 reset", 16'h2001, rd);
    rd_reg(REG_NP_RX, MY_PHY);
    chk("reg8 reset", 16'h0000, rd);
    chk("pending reset", 16'h0000, {15'h0000, tx_page_pending});
    $display("test reset done");
  endtask : t_reset

  task automatic t_flags;
    partner_np_able = 1'b1;
    partner_an_able = 1'b1;
    @(posedge core_clk);
    #1 page_rx = np_page_t'(15'h7da5);
    page_rx_valid   = 1'b1;
    par_fault_event = 1'b1;
    @(posedge core_clk);
    #1 page_rx_valid = 1'b0;
    par_fault_event = 1'b0;
    page_rx = np_page_t'(15'h0000);
    rd_reg(REG_NP_RX, MY_PHY);
    chk("reg8 page", 16'hbda5, rd);
    rd_reg(REG_EXPANSION, MY_PHY);
    chk("reg6 flags", 16'h001f, rd);
    rd_reg(REG_EXPANSION, MY_PHY);
    chk("reg6 cleared", 16'h000d, rd);
    $display("test flags done");
  endtask : t_flags

  task automatic t_write;
    wr_reg(REG_NP_TX, MY_PHY, 16'hffff);
    chk("pending set", 16'h0001, {15'h0000, tx_page_pending});
    chk("tx_page out", 16'h77ff, {1'b0, tx_page});
    rd_reg(REG_NP_TX, MY_PHY);
    chk("reg7 write", 16'hb7ff, rd);
    wr_reg(REG_EXPANSION, MY_PHY, 16'hffff);
    wr_reg(REG_NP_RX, MY_PHY, 16'h0000);
    rd_reg(REG_EXPANSION, MY_PHY);
    chk("reg6 ro", 16'h000d, rd);
    rd_reg(REG_NP_RX, MY_PHY);
    chk("reg8 ro", 16'hbda5, rd);
    $display("test write done");
  endtask : t_write

  task automatic t_taken;
    @(posedge core_clk);
    #1 tx_page_taken = 1'b1;
    @(posedge core_clk);
    #1 tx_page_taken = 1'b0;
    @(posedge core_clk);
    #1;
    chk("pending clr", 16'h0000, {15'h0000, tx_page_pending});
    rd_reg(REG_NP_TX, MY_PHY);
    chk("reg7 toggled", 16'hbfff, rd);
    wr_reg(REG_NP_TX, MY_PHY, 16'h0000);
    rd_reg(REG_NP_TX, MY_PHY);
    chk("reg7 toggle kept", 16'h0800, rd);
    $display("test taken done");
  endtask : t_taken

  // slow station: other phy and unmapped offset
  task automatic t_refuse;
    u_sta.half_cycles = 5;
    rd_reg(REG_NP_TX, 5'h04);
    chk("other phy read", 16'hffff, rd);
    wr_reg(REG_NP_TX, 5'h04, 16'h8001);
    rd_reg(5'h09, MY_PHY);
    chk("unmapped read", 16'h0000, rd);
    // illegal opcode: device drops the frame and leaves the line to the pull-up
    u_sta.frame(2'b11, MY_PHY, REG_NP_TX, 16'h0000, rd);
    chk("bad opcode read", 16'hffff, rd);
    rd_reg(REG_NP_TX, MY_PHY);
    chk("reg7 untouched", 16'h0800, rd);
    $display("test refuse done");
  endtask : t_refuse

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: 20 frames of at most 640 core cycles
  initial begin
    repeat (40000) @(posedge core_clk);
    err_count++;
    $display("[FAIL] watchdog expected done seen hang");
    wrap_up();
  end

  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    page_rx_valid = 1'b0;
    page_rx = np_page_t'(15'h0000);
    par_fault_event = 1'b0;
    partner_np_able = 1'b0;
    partner_an_able = 1'b0;
    tx_page_taken = 1'b0;
    err_count = 0;
    checked = 0;
    repeat (4) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    // next page advertisement enable is set outside this bank
    t_reset();
    t_flags();
    t_write();
    t_taken();
    t_refuse();
    wrap_up();
  end
endmodule : tb_autoneg_next_page_regs
`default_nettype wire
